// file: rtl/pmm_meas.sv
`timescale 1ns/1ps
module pmm_meas #(
    parameter int CT_CYC [8] = pmm_pkg::CT_CYCLES
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    input wire logic signed [15:0] SHUNT_SAMPLE,
    input wire logic [14:0] BUS_SAMPLE,
    output logic BUSY
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // A zero count, or one too wide for the down-counter, would hang a code
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_ct_check
        if (CT_CYC[gi] < 1 || CT_CYC[gi] >= (1 << pmm_pkg::CT_W))
        begin : g_bad_count
            $error("pmm_meas: conversion count out of range");
        end
    end

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    // Calibration keeps 15 bits; its top bit always reads zero
    pmm_pkg::pmm_setup_t setup_q;
    logic [14:0] cal_q;
    logic setup_wr;
    logic soft_rst;

    // Write decode; a soft reset rides on a setup write
    assign setup_wr = REG_WR && (REG_ADDR == pmm_pkg::ADDR_SETUP);
    assign soft_rst = setup_wr && REG_WDATA[15];

    // Setup and calibration; writes to result offsets are dropped
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            setup_q <= pmm_pkg::SETUP_RESET;
            cal_q <= pmm_pkg::CAL_RESET;
        end
        else if (CE)
        begin
            if (soft_rst)
            begin
                setup_q <= pmm_pkg::SETUP_RESET;
                cal_q <= pmm_pkg::CAL_RESET;
            end
            else if (setup_wr)
            begin
                setup_q <= REG_WDATA;
                setup_q.soft_reset <= 1'b0; // Self-clearing
                setup_q.reserved <= pmm_pkg::SETUP_RSVD; // Not writable
            end
            else if (REG_WR && REG_ADDR == pmm_pkg::ADDR_CAL)
                cal_q <= REG_WDATA[14:0];
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic shunt_en;
    logic bus_en;
    logic continuous;
    logic active;
    logic [3:0] avg_shift;
    logic [10:0] last_idx;

    // Bit 0 picks shunt, bit 1 bus, bit 2 repeats; 000 and 100 stay idle
    assign shunt_en = setup_q.mode[0];
    assign bus_en = setup_q.mode[1];
    assign continuous = setup_q.mode[2];
    assign active = shunt_en || bus_en;
    assign avg_shift = pmm_pkg::AVG_SHIFT[setup_q.sample_count_sel];
    assign last_idx = 11'((1 << avg_shift) - 1);

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // Sample index counts 0 to N-1 within one averaged set
    pmm_pkg::pmm_state_t state_q;
    logic [pmm_pkg::CT_W-1:0] cnt_q;
    logic [10:0] idx_q;
    logic run_q;
    logic tick;
    logic shunt_add;
    logic bus_add;
    logic acc_clr;
    logic [pmm_pkg::CT_W-1:0] shunt_ct;
    logic [pmm_pkg::CT_W-1:0] bus_ct;

    // Counter loads count minus one, so tick marks the last cycle
    assign tick = (cnt_q == '0);
    assign shunt_ct = pmm_pkg::CT_W'(CT_CYC[setup_q.shunt_conv_time_sel] - 1);
    assign bus_ct = pmm_pkg::CT_W'(CT_CYC[setup_q.bus_conv_time_sel] - 1);
    assign shunt_add = (state_q == pmm_pkg::PMM_SHUNT_CONV) && tick;
    assign bus_add = (state_q == pmm_pkg::PMM_BUS_CONV) && tick;
    // A setup write throws away the partial sums of the aborted run
    assign acc_clr = setup_wr || (state_q == pmm_pkg::PMM_CALC_P);
    assign BUSY = (state_q != pmm_pkg::PMM_IDLE);

    // Setup write re-arms from idle with fresh settings; triggered
    // modes drop run_q after one complete averaged set
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_q <= pmm_pkg::PMM_IDLE;
            cnt_q <= '0;
            idx_q <= '0;
            run_q <= 1'b1;
        end
        else if (CE)
        begin
            if (setup_wr)
            begin
                state_q <= pmm_pkg::PMM_IDLE;
                idx_q <= '0;
                cnt_q <= '0;
                run_q <= soft_rst || (REG_WDATA[1:0] != 2'h0);
            end
            else
            begin
                cnt_q <= tick ? '0 : cnt_q - 1'b1;
                case (state_q)
                    pmm_pkg::PMM_IDLE:
                    begin
                        if (run_q && active)
                        begin
                            state_q <= shunt_en ? pmm_pkg::PMM_SHUNT_CONV
                                                : pmm_pkg::PMM_BUS_CONV;
                            cnt_q <= shunt_en ? shunt_ct : bus_ct;
                        end
                    end
                    pmm_pkg::PMM_SHUNT_CONV, pmm_pkg::PMM_BUS_CONV:
                    begin
                        if (tick)
                        begin
                            if (state_q == pmm_pkg::PMM_SHUNT_CONV && bus_en)
                            begin
                                state_q <= pmm_pkg::PMM_BUS_CONV;
                                cnt_q <= bus_ct;
                            end
                            else if (idx_q == last_idx)
                            begin
                                state_q <= pmm_pkg::PMM_LATCH;
                                idx_q <= '0;
                            end
                            else
                            begin
                                idx_q <= idx_q + 1'b1;
                                state_q <= shunt_en ? pmm_pkg::PMM_SHUNT_CONV
                                                    : pmm_pkg::PMM_BUS_CONV;
                                cnt_q <= shunt_en ? shunt_ct : bus_ct;
                            end
                        end
                    end
                    pmm_pkg::PMM_LATCH:
                        state_q <= pmm_pkg::PMM_CALC_I;
                    pmm_pkg::PMM_CALC_I:
                        state_q <= pmm_pkg::PMM_CALC_P;
                    pmm_pkg::PMM_CALC_P:
                    begin
                        state_q <= pmm_pkg::PMM_IDLE;
                        run_q <= continuous;
                    end
                    default:
                        state_q <= pmm_pkg::PMM_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Averagers
    // ------------------------------------------------------------
    // Running means of the current set, cleared between sets
    logic signed [15:0] shunt_avg;
    logic signed [15:0] bus_avg;

    // Shunt samples are signed and sign-extend into the sum
    pmm_avg #(.W(16), .SHIFT_MAX(pmm_pkg::AVG_MAX_SHIFT)) u_shunt_avg (
        .clk(CLOCK),
        .nrst(NRST),
        .ce(CE),
        .clr(acc_clr),
        .add(shunt_add),
        .sample(SHUNT_SAMPLE),
        .shift(avg_shift),
        .avg(shunt_avg)
    );

    // Bus samples enter as positive words with a zero top bit
    pmm_avg #(.W(16), .SHIFT_MAX(pmm_pkg::AVG_MAX_SHIFT)) u_bus_avg (
        .clk(CLOCK),
        .nrst(NRST),
        .ce(CE),
        .clr(acc_clr),
        .add(bus_add),
        .sample({1'b0, BUS_SAMPLE}),
        .shift(avg_shift),
        .avg(bus_avg)
    );

    // ------------------------------------------------------------
    // Current and power arithmetic
    // ------------------------------------------------------------
    // Products stay within 32 bits; the widest is about 2^30
    pmm_pkg::pmm_results_t res_q;
    logic signed [31:0] cur_prod;
    logic signed [31:0] cur_scaled;
    logic [15:0] cur_sat;
    logic [16:0] cur_mag;
    logic [31:0] pow_prod;
    logic [31:0] pow_scaled;
    logic [15:0] pow_sat;

    // Shunt LSB 2.5 uV, so 7FFF reads 81.9175 mV; unsigned calibration
    // keeps the current sign equal to the shunt sign
    assign cur_prod = 32'(signed'(res_q.shunt_value_bits)) * 32'(signed'({17'h0, cal_q}));
    assign cur_scaled = cur_prod >>> pmm_pkg::CUR_SHIFT;
    // Saturate rather than wrap so an overrange never flips the sign
    always_comb
    begin
        if (cur_scaled > 32'sh00007FFF)
            cur_sat = pmm_pkg::SAT_POS;
        else if (cur_scaled < -32'sh00008000)
            cur_sat = pmm_pkg::SAT_NEG;
        else
            cur_sat = cur_scaled[15:0];
    end

    // Bus LSB 1.25 mV against a 25x power LSB gives the divisor
    assign cur_mag = res_q.current_value_bits[15] ?
        17'(-signed'({res_q.current_value_bits[15], res_q.current_value_bits})) :
        {1'b0, res_q.current_value_bits};
    assign pow_prod = 32'(cur_mag) * 32'(res_q.bus_value_bits);
    assign pow_scaled = pow_prod / pmm_pkg::POWER_DIV;
    assign pow_sat = (pow_scaled > 32'h0000FFFF) ? 16'hFFFF : pow_scaled[15:0];

    // Results move only at the end of a full averaged set or on a soft reset, which clears them; power-down
    // and other aborted runs leave them untouched
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            res_q <= {4{pmm_pkg::RESULT_RESET}};
        else if (CE)
        begin
            if (soft_rst)
                res_q <= {4{pmm_pkg::RESULT_RESET}};
            else if (!setup_wr)
            begin
                if (state_q == pmm_pkg::PMM_LATCH && shunt_en)
                    res_q.shunt_value_bits <= shunt_avg;
                if (state_q == pmm_pkg::PMM_LATCH && bus_en)
                    res_q.bus_value_bits <= {1'b0, bus_avg[14:0]};
                if (state_q == pmm_pkg::PMM_CALC_I)
                    res_q.current_value_bits <= cur_sat;
                if (state_q == pmm_pkg::PMM_CALC_P)
                    res_q.power_value_bits <= pow_sat;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Registered read: data for REG_ADDR appears one cycle later
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            REG_RDATA <= '0;
        else if (CE)
        begin
            case (REG_ADDR)
                pmm_pkg::ADDR_SETUP:
                    REG_RDATA <= setup_q;
                pmm_pkg::ADDR_SHUNT:
                    REG_RDATA <= res_q.shunt_value_bits;
                pmm_pkg::ADDR_BUS:
                    REG_RDATA <= res_q.bus_value_bits;
                pmm_pkg::ADDR_POWER:
                    REG_RDATA <= res_q.power_value_bits;
                pmm_pkg::ADDR_CURRENT:
                    REG_RDATA <= res_q.current_value_bits;
                pmm_pkg::ADDR_CAL:
                    REG_RDATA <= {1'b0, cal_q};
                // Unmapped pointers read as zero
                default:
                    REG_RDATA <= '0;
            endcase
        end
    end
endmodule : pmm_meas

// file: inc/pmm_pkg.sv
package pmm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_SHUNT = 8'h01;
    localparam logic [7:0] ADDR_BUS = 8'h02;
    localparam logic [7:0] ADDR_POWER = 8'h03;
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    localparam logic [7:0] ADDR_CAL = 8'h05;

    localparam logic [15:0] SETUP_RESET = 16'h4127;
    localparam logic [2:0] SETUP_RSVD = 3'h4;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [14:0] CAL_RESET = 15'h0000;
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;

    // Setup register layout, bit 15 down to bit 0
    typedef struct packed {
        logic soft_reset;
        logic [2:0] reserved;
        logic [2:0] sample_count_sel;
        logic [2:0] bus_conv_time_sel;
        logic [2:0] shunt_conv_time_sel;
        logic [2:0] mode;
    } pmm_setup_t;

    // Snapshot of the four result words
    typedef struct packed {
        logic [15:0] shunt_value_bits;
        logic [15:0] bus_value_bits;
        logic [15:0] power_value_bits;
        logic [15:0] current_value_bits;
    } pmm_results_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CT_W = 19;
    localparam int CT_TIME_NS [8] = '{140000, 204000, 332000, 588000,
                                      1100000, 2116000, 4156000, 8244000};
    localparam int CT_CYCLES [8] = '{CT_TIME_NS[0] / CLK_PERIOD_NS,
                                     CT_TIME_NS[1] / CLK_PERIOD_NS,
                                     CT_TIME_NS[2] / CLK_PERIOD_NS,
                                     CT_TIME_NS[3] / CLK_PERIOD_NS,
                                     CT_TIME_NS[4] / CLK_PERIOD_NS,
                                     CT_TIME_NS[5] / CLK_PERIOD_NS,
                                     CT_TIME_NS[6] / CLK_PERIOD_NS,
                                     CT_TIME_NS[7] / CLK_PERIOD_NS};

    // Averaging: counts 1,4,16,64,128,256,512,1024 as shifts
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                             4'h7, 4'h8, 4'h9, 4'hA};
    localparam int AVG_MAX_SHIFT = 10;

    // Arithmetic scaling
    localparam int CUR_SHIFT = 11;
    localparam logic [31:0] POWER_DIV = 32'h00004E20;

    typedef enum {
        PMM_IDLE,
        PMM_SHUNT_CONV,
        PMM_BUS_CONV,
        PMM_LATCH,
        PMM_CALC_I,
        PMM_CALC_P
    } pmm_state_t;

endpackage : pmm_pkg

// file: rtl/pmm_avg.sv
`timescale 1ns/1ps
module pmm_avg #(
    parameter int W = 16,
    parameter int SHIFT_MAX = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clr,
    input wire logic add,
    input wire logic signed [W-1:0] sample,
    input wire logic [3:0] shift,
    output logic signed [W-1:0] avg
);
    localparam int SW = W + SHIFT_MAX;

    logic signed [SW-1:0] sum_q;
    logic signed [SW-1:0] shifted;

    // The shift port is four bits wide, so deeper averaging cannot be served
    if (W < 2 || SHIFT_MAX < 1 || SHIFT_MAX > 15)
    begin : g_bad_param
        $error("pmm_avg: unsupported width or shift");
    end

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    // Clear wins over add so an aborted run leaves no partial sum
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sum_q <= '0;
        else if (ce)
        begin
            if (clr)
                sum_q <= '0;
            else if (add)
                sum_q <= sum_q + SW'(sample);
        end
    end

    // Count is a power of two, so the mean is an arithmetic shift
    assign shifted = sum_q >>> shift;
    assign avg = shifted[W-1:0];
endmodule : pmm_avg

// file: testbench/pmm_adc_model.sv
`timescale 1ns/1ps
module pmm_adc_model (
    input wire logic clock,
    input wire logic signed [15:0] shunt_level,
    input wire logic [14:0] bus_level,
    output logic signed [15:0] shunt_sample,
    output logic [14:0] bus_sample
);
    // Converter output register: one clock of lag, so levels are set well ahead of use
    always_ff @(posedge clock)
    begin
        shunt_sample <= shunt_level;
        bus_sample <= bus_level;
    end
endmodule : pmm_adc_model

// file: testbench/pmm_meas_props.sv
`timescale 1ns/1ps
module pmm_meas_chk (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic BUSY
);
    logic [2:0] mode_q;
    logic cal_zero_q;
    // Mirror of the mode field; a soft reset brings back the continuous default
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            mode_q <= 3'h7;
        else if (CE && REG_WR && REG_ADDR == pmm_pkg::ADDR_SETUP)
            mode_q <= REG_WDATA[15] ? 3'h7 : REG_WDATA[2:0];
    end
    // Tracks whether the calibration word is still zero
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            cal_zero_q <= 1'b1;
        else if (CE && REG_WR && REG_ADDR == pmm_pkg::ADDR_CAL)
            cal_zero_q <= (REG_WDATA[14:0] == 15'h0000);
        else if (CE && REG_WR && REG_ADDR == pmm_pkg::ADDR_SETUP && REG_WDATA[15])
            cal_zero_q <= 1'b1;
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    sequence setup_wr_s;
        CE && REG_WR && REG_ADDR == pmm_pkg::ADDR_SETUP;
    endsequence
    sequence restart_s;
        !BUSY ##1 BUSY;
    endsequence
    chk_bus_top_bit: assert property (
        $past(CE) && $past(REG_ADDR) == pmm_pkg::ADDR_BUS |-> !REG_RDATA[15])
        else $error("bus result top bit set");
    chk_cal_zero_out: assert property (
        cal_zero_q && $past(CE) && ($past(REG_ADDR) == pmm_pkg::ADDR_CURRENT
        || $past(REG_ADDR) == pmm_pkg::ADDR_POWER) |-> REG_RDATA == 16'h0000)
        else $error("nonzero current or power with zero calibration");
    chk_reset_run: assert property (
        !$past(NRST) |-> ##[1:3] BUSY)
        else $error("no measuring after reset");
    chk_write_abort: assert property (
        setup_wr_s |=> !BUSY)
        else $error("setup write did not abort");
    chk_write_restart: assert property (
        setup_wr_s ##0 (REG_WDATA[1:0] != 2'h0 && !REG_WDATA[15]) |=> restart_s)
        else $error("no restart after setup write");
    chk_pdown_idle: assert property (
        setup_wr_s ##0 (REG_WDATA[1:0] == 2'h0 && !REG_WDATA[15]) |=> !BUSY [*8])
        else $error("converting in power-down");
    chk_trig_stop: assert property (
        $fell(BUSY) && !mode_q[2] && !$past(CE && REG_WR) |-> !BUSY [*8])
        else $error("triggered mode did not stop");
    chk_cont_rerun: assert property (
        $fell(BUSY) && mode_q[2] && mode_q[1:0] != 2'h0 && !$past(CE && REG_WR)
        && CE && !(REG_WR && REG_ADDR == pmm_pkg::ADDR_SETUP) |=> BUSY)
        else $error("continuous mode did not rerun");
endmodule : pmm_meas_chk

bind pmm_meas pmm_meas_chk u_pmm_chk (.CLOCK(CLOCK), .NRST(NRST), .CE(CE),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .BUSY(BUSY));

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    // Short conversion times keep the run brief; expectations derive from this table
    localparam int CT_TB [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
    logic CLOCK = 1'b0;
    logic NRST = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic signed [15:0] sh_lvl = 16'shFC18;
    logic [14:0] bus_lvl = 15'h3E80;
    logic signed [15:0] sh_smp;
    logic [14:0] bus_smp;
    logic busy;
    int err_total = 0;
    int n_compared = 0;
    int d0;
    int d1;
    int d2;
    int d;

    always #10 CLOCK = ~CLOCK;

    pmm_adc_model u_adc (.clock(CLOCK), .shunt_level(sh_lvl), .bus_level(bus_lvl),
        .shunt_sample(sh_smp), .bus_sample(bus_smp));
    pmm_meas #(.CT_CYC(CT_TB)) DUT (.CLOCK(CLOCK), .NRST(NRST), .CE(1'b1),
        .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .SHUNT_SAMPLE(sh_smp), .BUS_SAMPLE(bus_smp), .BUSY(busy));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe; the pointer stays put afterwards
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge CLOCK);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge CLOCK);
        wr <= 1'b0;
    endtask : reg_wr

    // Read data is registered, so it is taken two cycles after the pointer lands
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CLOCK);
        addr <= a;
        repeat (2) @(posedge CLOCK);
        #1;
        check(rdata, exp);
    endtask : rd_chk

    // Length of one triggered run; the trailing idle lets the stop be observed
    task automatic run_len(input logic [15:0] setup, output int n);
        int k;
        n = 0;
        k = 0;
        reg_wr(pmm_pkg::ADDR_SETUP, setup);
        // Busy still shows the old state in the write's own time step
        #1;
        while (busy !== 1'b1 && k < 5)
        begin
            @(posedge CLOCK);
            #1;
            k++;
        end
        while (busy === 1'b1 && n < 3000)
        begin
            @(posedge CLOCK);
            #1;
            n++;
        end
        if (k == 5 || n == 3000)
        begin
            err_total++;
            $display("MISMATCH %0t busy wait ran out", $time);
            tally_and_finish();
        end
        repeat (10) @(posedge CLOCK);
    endtask : run_len

    initial
    begin
        repeat (20) @(posedge CLOCK);
        NRST <= 1'b1;
        rd_chk(8'h00, 16'h4127);
        for (int a = 1; a < 5; a++)
            rd_chk(8'(a), 16'h0000);
        repeat (60) @(posedge CLOCK);
        rd_chk(8'h04, 16'h0000);
        rd_chk(8'h03, 16'h0000);
        rd_chk(8'h01, 16'hFC18);
        rd_chk(8'h02, 16'h3E80);
        rd_chk(8'h09, 16'h0000);
        reg_wr(8'h05, 16'h0800);
        reg_wr(8'h00, 16'h4003);
        repeat (60) @(posedge CLOCK);
        rd_chk(8'h04, 16'hFC18);
        rd_chk(8'h03, 16'h0320);
        reg_wr(8'h01, 16'h1234);
        rd_chk(8'h01, 16'hFC18);
        sh_lvl <= 16'sh0100;
        bus_lvl <= 15'h7FFF;
        reg_wr(8'h00, 16'h4203);
        repeat (100) @(posedge CLOCK);
        rd_chk(8'h02, 16'h7FFF);
        rd_chk(8'h04, 16'h0100);
        rd_chk(8'h03, 16'h01A3);
        sh_lvl <= 16'sh0055;
        reg_wr(8'h00, 16'h4200);
        repeat (60) @(posedge CLOCK);
        rd_chk(8'h01, 16'h0100);
        reg_wr(8'h00, 16'h4003);
        repeat (60) @(posedge CLOCK);
        rd_chk(8'h01, 16'h0055);
        sh_lvl <= 16'sh0077;
        repeat (60) @(posedge CLOCK);
        rd_chk(8'h01, 16'h0055);
        // Every mode code: busy cycles in a window tell off, single run, repeating
        for (int m = 0; m < 8; m++)
        begin
            reg_wr(8'h00, {13'h0800, 3'(m)});
            d = 0;
            repeat (60)
            begin
                @(posedge CLOCK);
                #1;
                if (busy === 1'b1)
                    d++;
            end
            check(16'((d == 0) ? 0 : ((d < 40) ? 1 : 2)), 16'((m % 4 == 0) ? 0 : 1 + m / 4));
        end
        run_len(16'h4003, d0);
        run_len(16'h4001, d1);
        run_len(16'h4002, d2);
        for (int b = 1; b < 8; b++)
        begin
            run_len(16'h4003 | 16'(b << 6), d);
            check(16'(d - d0), 16'(CT_TB[b] - CT_TB[0]));
            run_len(16'h4003 | 16'(b << 3), d);
            check(16'(d - d0), 16'(CT_TB[b] - CT_TB[0]));
            run_len(16'h4001 | 16'(b << 6), d);
            check(16'(d), 16'(d1));
            run_len(16'h4002 | 16'(b << 3), d);
            check(16'(d), 16'(d2));
        end
        reg_wr(8'h00, 16'h8000);
        repeat (3) @(posedge CLOCK);
        rd_chk(8'h00, 16'h4127);
        rd_chk(8'h04, 16'h0000);
        tally_and_finish();
    end
endmodule : testbench
